/* design/dtmc_core.v */
// Purpose: timing and mode registers plus per-bank spacing and refresh timing
// Assumes: dram clock equals clk_in; sequencer obeys the ok flags
// Notes: reserved encodings are stored as written; cas code 3 decodes as 2.5 and refresh codes 4 to 6 disable refresh
`include "dtmc_consts.vh"
module dtmc_core #(
  parameter NB = 4,
  parameter BW = 2,
  parameter integer TRAS_MAX_SLOW_CYC = `DTMC_TRAS_MAX_SLOW_CYC,
  parameter integer TRAS_MAX_FAST_CYC = `DTMC_TRAS_MAX_FAST_CYC,
  parameter integer RAS_MAX_MARGIN = 16,
  parameter integer REF_15U6_CYC = `DTMC_REF_15U6_CYC,
  parameter integer REF_7U8_CYC = `DTMC_REF_7U8_CYC,
  parameter integer REF_64U_CYC = `DTMC_REF_64U_CYC
) (
  input wire clk_in,
  input wire rst_in,
  input wire [7:0] reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [3:0] reg_be_in,
  input wire [31:0] reg_wdata_in,
  output wire [31:0] reg_rdata_out,
  output wire reg_rvalid_out,
  input wire dual_channel_in,
  input wire cmd_act_in,
  input wire cmd_pre_in,
  input wire [BW-1:0] cmd_bank_in,
  output wire [NB-1:0] act_ok_out,
  output wire [NB-1:0] pre_ok_out,
  output wire [NB-1:0] rdwr_ok_out,
  output wire [NB-1:0] bank_open_out,
  output wire [NB-1:0] pre_due_out,
  output wire [2:0] cas_half_clk_out,
  output wire ecc_enable_out,
  output wire init_done_out,
  output wire refresh_req_out
);
  localparam [31:0] TMAX_SLOW = TRAS_MAX_SLOW_CYC - RAS_MAX_MARGIN;
  localparam [31:0] TMAX_FAST = TRAS_MAX_FAST_CYC - RAS_MAX_MARGIN;
  localparam [31:0] REF_A = REF_15U6_CYC - 1;
  localparam [31:0] REF_B = REF_7U8_CYC - 1;
  localparam [31:0] REF_C = REF_64U_CYC - 1;
  localparam [31:0] REF_F = `DTMC_REF_FAST_CYC - 1;

  reg [31:0] timing_r;
  reg [31:0] mode_r;
  reg [1:0] channel_count_field_r;
  reg strap_taken_r;
  reg [31:0] rdata_r;
  reg rvalid_r;
  reg [2:0] cas_half_r;
  reg ecc_r;
  reg init_r;
  reg refresh_req_r;
  reg wr_mode_d_r;
  reg [31:0] be_mask;
  reg [31:0] mode_view;
  reg [15:0] tras_min_cyc;
  reg [15:0] trcd_cyc;
  reg [15:0] trp_cyc;
  reg [15:0] tmax_cyc;
  reg [15:0] ref_cyc;
  reg ref_en;
  reg [2:0] cas_half_nxt;
  wire wr_timing;
  wire wr_mode;
  wire ref_done;
  wire ref_load;

  assign wr_timing = reg_wr_in & (reg_addr_in == `DTMC_OFS_TIMING);
  assign wr_mode = reg_wr_in & (reg_addr_in == `DTMC_OFS_MODE);

  always @* begin
    be_mask = {{8{reg_be_in[3]}}, {8{reg_be_in[2]}}, {8{reg_be_in[1]}}, {8{reg_be_in[0]}}};
    // channel field and dram type are not storable, they are merged at read time
    mode_view = mode_r | `DTMC_MODE_RO_TYPE;
    mode_view[`DTMC_CHANNEL_COUNT_FIELD_HI:`DTMC_CHANNEL_COUNT_FIELD_LO] = channel_count_field_r;
  end

  // register file; writes land at the edge, timers pick them up next cycle
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      timing_r <= `DTMC_TIMING_RST;
      mode_r <= `DTMC_MODE_RST & `DTMC_MODE_WMASK;
      rdata_r <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end else begin
      if (wr_timing) begin
        timing_r <= (timing_r & ~(be_mask & `DTMC_TIMING_WMASK)) |
                    (reg_wdata_in & be_mask & `DTMC_TIMING_WMASK);
      end
      if (wr_mode) begin
        mode_r <= (mode_r & ~(be_mask & `DTMC_MODE_WMASK)) |
                  (reg_wdata_in & be_mask & `DTMC_MODE_WMASK);
      end
      rvalid_r <= reg_rd_in;
      if (reg_rd_in) begin
        if (reg_addr_in == `DTMC_OFS_TIMING) begin
          rdata_r <= timing_r;
        end else if (reg_addr_in == `DTMC_OFS_MODE) begin
          rdata_r <= mode_view;
        end else begin
          rdata_r <= 32'h0000_0000;
        end
      end
    end
  end

  // strap is caught by the clock after release, never by the reset itself
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      channel_count_field_r <= 2'h0;
      strap_taken_r <= 1'b0;
    end else if (!strap_taken_r) begin
      channel_count_field_r <= {1'b0, dual_channel_in};
      strap_taken_r <= 1'b1;
    end
  end

  // decode of the timing and refresh fields
  always @* begin
    tras_min_cyc = `DTMC_TRAS_MIN_BASE -
                   {13'h0000, timing_r[`DTMC_TRAS_MIN_HI:`DTMC_TRAS_MIN_LO]};
    trcd_cyc = `DTMC_TRCD_BASE - {14'h0000, timing_r[`DTMC_TRCD_HI:`DTMC_TRCD_LO]};
    trp_cyc = `DTMC_TRP_BASE - {14'h0000, timing_r[`DTMC_TRP_HI:`DTMC_TRP_LO]};
    // margin lets the sequencer finish a burst before the hard limit
    tmax_cyc = timing_r[`DTMC_TRAS_MAX_BIT] ? TMAX_FAST[15:0] : TMAX_SLOW[15:0];
    case (timing_r[`DTMC_CL_HI:`DTMC_CL_LO])
      2'h1: cas_half_nxt = `DTMC_CL_HALF_2;
      2'h2: cas_half_nxt = `DTMC_CL_HALF_3;
      default: cas_half_nxt = `DTMC_CL_HALF_25;
    endcase
    ref_en = 1'b1;
    case (mode_r[`DTMC_RMS_HI:`DTMC_RMS_LO])
      `DTMC_RMS_15U6: ref_cyc = REF_A[15:0];
      `DTMC_RMS_7U8: ref_cyc = REF_B[15:0];
      `DTMC_RMS_64U: ref_cyc = REF_C[15:0];
      `DTMC_RMS_FAST: ref_cyc = REF_F[15:0];
      default: begin
        ref_cyc = REF_F[15:0];
        ref_en = 1'b0;
      end
    endcase
  end

  // restart one cycle after a mode write, once the new rate is decoded;
  // loading on the write itself would run one interval at the old rate
  assign ref_load = wr_mode_d_r | (ref_en & ref_done & ~wr_mode);

  dtmc_timer #(.W(16)) u_ref (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .load_in(ref_load),
    .load_val_in(ref_cyc),
    .done_out(ref_done)
  );

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cas_half_r <= `DTMC_CL_HALF_25;
      ecc_r <= 1'b0;
      init_r <= 1'b0;
      refresh_req_r <= 1'b0;
      wr_mode_d_r <= 1'b0;
    end else begin
      wr_mode_d_r <= wr_mode;
      cas_half_r <= cas_half_nxt;
      ecc_r <= (mode_r[`DTMC_ECC_HI:`DTMC_ECC_LO] == `DTMC_ECC_ON);
      init_r <= mode_r[`DTMC_INIT_BIT];
      refresh_req_r <= ref_en & ref_done & ~wr_mode & ~wr_mode_d_r;
    end
  end

  // bank timers are indexed by bank only: in virtual single-channel mode
  // two cycles to different channels still space as one channel
  genvar b;
  generate
    for (b = 0; b < NB; b = b + 1) begin : g_bank
      localparam [BW-1:0] BI = b;
      wire act_b = cmd_act_in & (cmd_bank_in == BI);
      wire pre_b = cmd_pre_in & (cmd_bank_in == BI);
      wire tmax_done;
      reg open_r;
      reg due_r;

      dtmc_timer #(.W(16)) u_trp (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .load_in(pre_b),
        .load_val_in(trp_cyc),
        .done_out(act_ok_out[b])
      );
      dtmc_timer #(.W(16)) u_trcd (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .load_in(act_b),
        .load_val_in(trcd_cyc),
        .done_out(rdwr_ok_out[b])
      );
      dtmc_timer #(.W(16)) u_tras_min (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .load_in(act_b),
        .load_val_in(tras_min_cyc),
        .done_out(pre_ok_out[b])
      );
      dtmc_timer #(.W(16)) u_tras_max (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .load_in(act_b),
        .load_val_in(tmax_cyc),
        .done_out(tmax_done)
      );

      always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          open_r <= 1'b0;
          due_r <= 1'b0;
        end else begin
          if (act_b) begin
            open_r <= 1'b1;
          end else if (pre_b) begin
            open_r <= 1'b0;
          end
          due_r <= open_r & tmax_done & ~pre_b & ~act_b;
        end
      end

      assign bank_open_out[b] = open_r;
      assign pre_due_out[b] = due_r;
    end
  endgenerate

  assign reg_rdata_out = rdata_r;
  assign reg_rvalid_out = rvalid_r;
  assign cas_half_clk_out = cas_half_r;
  assign ecc_enable_out = ecc_r;
  assign init_done_out = init_r;
  assign refresh_req_out = refresh_req_r;
endmodule // dtmc_core

/* design/dtmc_timer.v */
// Purpose: loadable down counter with a registered expiry flag
// Assumes: load value counts clocks until done_out rises
// Notes: done_out is high from reset and whenever the count is zero
module dtmc_timer #(
  parameter W = 16
) (
  input wire clk_in,
  input wire rst_in,
  input wire load_in,
  input wire [W-1:0] load_val_in,
  output wire done_out
);
  reg [W-1:0] cnt_r;
  reg [W-1:0] cnt_nxt;
  reg done_r;

  always @* begin
    cnt_nxt = cnt_r;
    if (load_in) begin
      cnt_nxt = load_val_in;
    end else if (cnt_r != {W{1'b0}}) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= {W{1'b0}};
      done_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= (cnt_nxt == {W{1'b0}});
    end
  end

  assign done_out = done_r;
endmodule // dtmc_timer

/* shared/dtmc_consts.vh */
// Purpose: constants of the dram timing and mode configuration core
// Assumes: one dram clock per clk_in cycle, clk_in at 100 MHz
// Notes: times in ns, cycle counts derived from the clock period
// Function
// - virtual single channel shares all spacing timers
// - bit 10 picks 120 or 70 us limit
// - bits 9:7 give 10 down to 3 clocks
// - bits 6:5 give read cas latency
// - bits 3:2 give activate to read/write clocks
// - bits 1:0 give precharge to activate clocks
// - bit 29 software init done flag
// - bits 22:21 report channel organisation, read only
// - bits 19:18 select ecc or no ecc
// - bits 10:8 enable refresh, choose interval
// - code 111 refreshes every 64 clocks
`ifndef DTMC_CONSTS_VH
`define DTMC_CONSTS_VH

`define DTMC_CLK_NS 10
`define DTMC_OFS_TIMING 8'h60
`define DTMC_OFS_MODE 8'h68
`define DTMC_TIMING_RST 32'h0000_0000
`define DTMC_TIMING_WMASK 32'h0000_07EF
`define DTMC_MODE_RST 32'h0000_0001
`define DTMC_MODE_WMASK 32'h200C_0700
`define DTMC_MODE_RO_TYPE 32'h0000_0001

`define DTMC_TRAS_MAX_BIT 10
`define DTMC_TRAS_MIN_HI 9
`define DTMC_TRAS_MIN_LO 7
`define DTMC_CL_HI 6
`define DTMC_CL_LO 5
`define DTMC_TRCD_HI 3
`define DTMC_TRCD_LO 2
`define DTMC_TRP_HI 1
`define DTMC_TRP_LO 0
`define DTMC_INIT_BIT 29
`define DTMC_CHANNEL_COUNT_FIELD_HI 22
`define DTMC_CHANNEL_COUNT_FIELD_LO 21
`define DTMC_ECC_HI 19
`define DTMC_ECC_LO 18
`define DTMC_RMS_HI 10
`define DTMC_RMS_LO 8

`define DTMC_TRAS_MIN_BASE 16'h000A
`define DTMC_TRCD_BASE 16'h0004
`define DTMC_TRP_BASE 16'h0004
`define DTMC_CL_HALF_25 3'h5
`define DTMC_CL_HALF_2 3'h4
`define DTMC_CL_HALF_3 3'h6

`define DTMC_RMS_15U6 3'h1
`define DTMC_RMS_7U8 3'h2
`define DTMC_RMS_64U 3'h3
`define DTMC_RMS_FAST 3'h7
`define DTMC_ECC_ON 2'h1

`define DTMC_TRAS_MAX_SLOW_NS 120000
`define DTMC_TRAS_MAX_FAST_NS 70000
`define DTMC_REF_15U6_NS 15600
`define DTMC_REF_7U8_NS 7800
`define DTMC_REF_64U_NS 64000
`define DTMC_REF_FAST_CYC 64
`define DTMC_TRAS_MAX_SLOW_CYC (`DTMC_TRAS_MAX_SLOW_NS / `DTMC_CLK_NS)
`define DTMC_TRAS_MAX_FAST_CYC (`DTMC_TRAS_MAX_FAST_NS / `DTMC_CLK_NS)
`define DTMC_REF_15U6_CYC (`DTMC_REF_15U6_NS / `DTMC_CLK_NS)
`define DTMC_REF_7U8_CYC (`DTMC_REF_7U8_NS / `DTMC_CLK_NS)
`define DTMC_REF_64U_CYC (`DTMC_REF_64U_NS / `DTMC_CLK_NS)

`endif

/* tb/dtmc_core_assertions.sv */
// Purpose: port-level checks of the timing and mode core
// Assumes: default NB and BW, write strobe one cycle wide
// Notes: bank 0 carries the spacing checks
module dtmc_core_assertions (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [3:0] reg_be_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_rvalid_out,
  input wire logic cmd_act_in,
  input wire logic cmd_pre_in,
  input wire logic [1:0] cmd_bank_in,
  input wire logic [3:0] act_ok_out,
  input wire logic [3:0] pre_ok_out,
  input wire logic [3:0] rdwr_ok_out,
  input wire logic [2:0] cas_half_clk_out,
  input wire logic ecc_enable_out,
  input wire logic init_done_out,
  input wire logic refresh_req_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic fast_r;
  wire [2:0] cas_exp = (reg_wdata_in[6:5] == 2'h1) ? 3'h4 : (reg_wdata_in[6:5] == 2'h2) ? 3'h6 : 3'h5;
  wire wr_t = reg_wr_in && reg_addr_in == 8'h60 && reg_be_in[0];
  wire wr_m = reg_wr_in && reg_addr_in == 8'h68;
  wire act0 = cmd_act_in && cmd_bank_in == 2'h0;
  wire pre0 = cmd_pre_in && cmd_bank_in == 2'h0;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fast_r <= 1'b0;
    end else if (wr_m && reg_be_in[1]) begin
      fast_r <= reg_wdata_in[10:8] == 3'h7;
    end
  end
  a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");
  a_rcd_spacing: assert property (act0 |=> !rdwr_ok_out[0] ##[2:4] rdwr_ok_out[0])
    else $error("act to rdwr spacing off");
  a_ras_min: assert property (act0 |=> !pre_ok_out[0] [*5] ##[1:6] pre_ok_out[0])
    else $error("act to pre spacing off");
  a_rp_spacing: assert property (pre0 |=> !act_ok_out[0] ##[2:4] act_ok_out[0])
    else $error("pre to act spacing off");
  a_cas_decode: assert property (wr_t |-> ##2 cas_half_clk_out == $past(cas_exp, 2))
    else $error("cas latency decode off");
  a_ecc_decode: assert property (wr_m && reg_be_in[2] |-> ##2
    ecc_enable_out == ($past(reg_wdata_in[19:18], 2) == 2'h1))
    else $error("ecc enable decode off");
  a_init_flag: assert property (wr_m && reg_be_in[3] |-> ##2 init_done_out == $past(reg_wdata_in[29], 2))
    else $error("init flag off");
  a_fast_period: assert property (refresh_req_out && fast_r |-> ##64 (refresh_req_out || !fast_r))
    else $error("fast refresh period off");
endmodule // dtmc_core_assertions
bind dtmc_core dtmc_core_assertions i_dtmc_core_assertions (.*);

/* tb/dtmc_seq_model.sv */
// Purpose: sequencer stand-in issuing activate and precharge
// Assumes: commands change 1 ns after the rising edge
// Notes: waits up to 20 cycles on the ok flags, then issues anyway and counts a stall
module dtmc_seq_model (
  input wire logic clk_in,
  input wire logic [3:0] act_ok_in,
  input wire logic [3:0] pre_ok_in,
  output logic cmd_act_out,
  output logic cmd_pre_out,
  output logic [1:0] cmd_bank_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int n_stall = 0;
  initial begin
    cmd_act_out = 1'b0;
    cmd_pre_out = 1'b0;
    cmd_bank_out = 2'h0;
  end
  task automatic issue(input logic act, input logic [1:0] bank);
    int n;
    n = 0;
    while (!(act ? act_ok_in[bank] : pre_ok_in[bank]) && n < 20) begin
      @(posedge clk_in) #1;
      n++;
    end
    // a flag that never comes back is counted, the bench judges it
    if (n >= 20) begin
      n_stall++;
    end
    cmd_bank_out = bank;
    cmd_act_out = act;
    cmd_pre_out = !act;
    @(posedge clk_in) #1;
    cmd_act_out = 1'b0;
    cmd_pre_out = 1'b0;
    // released bank lines do not keep the old value
    cmd_bank_out = ~bank;
  endtask
endmodule // dtmc_seq_model

/* tb/tb_top.sv */
// Purpose: self-checking bench of the timing and mode core
// Assumes: small tras max and refresh counts set below
// Notes: inputs change 1 ns after the rising edge
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [3:0] reg_be_in = 4'hF;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic dual_channel_in = 1'b0;
  logic cmd_act_in, cmd_pre_in, reg_rvalid_out, ecc_enable_out, init_done_out, refresh_req_out;
  logic [1:0] cmd_bank_in;
  logic [31:0] reg_rdata_out;
  logic [3:0] act_ok_out, pre_ok_out, rdwr_ok_out, bank_open_out, pre_due_out;
  logic [2:0] cas_half_clk_out;
  int n_mismatch = 0;
  int checks_done = 0;
  always #5 clk_in = ~clk_in;
  dtmc_core #(.TRAS_MAX_SLOW_CYC(200), .TRAS_MAX_FAST_CYC(150), .REF_15U6_CYC(90), .REF_7U8_CYC(70),
    .REF_64U_CYC(100)) i_dtmc_core (.*);
  dtmc_seq_model i_dtmc_seq_model (.clk_in(clk_in), .act_ok_in(act_ok_out), .pre_ok_in(pre_ok_out),
    .cmd_act_out(cmd_act_in), .cmd_pre_out(cmd_pre_in), .cmd_bank_out(cmd_bank_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    step(1);
    reg_wr_in = 1'b0;
    // idle cycle so a following strobe never rises in the same step
    step(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    step(1);
    reg_rd_in = 1'b0;
    chk({31'h0, reg_rvalid_out}, 32'h1);
    chk(reg_rdata_out, exp);
    step(1);
  endtask
  task automatic wait_ref(output int n);
    n = 0;
    while (refresh_req_out !== 1'b1) begin
      step(1);
      n++;
      if (n > 300) begin
        n_mismatch++;
        end_of_test();
      end
    end
  endtask
  task automatic t_regs();
    rd(8'h60, 32'h0000_0000);
    rd(8'h68, 32'h0000_0001);
    wr(8'h60, 32'hFFFF_FFFF);
    wr(8'h68, 32'hFFFF_FFFF);
    wr(8'h64, 32'hFFFF_FFFF);
    rd(8'h60, 32'h0000_07EF);
    rd(8'h68, 32'h200C_0701);
    rd(8'h64, 32'h0000_0000);
    reg_be_in = 4'h1;
    wr(8'h60, 32'h0000_0000);
    reg_be_in = 4'hF;
    rd(8'h60, 32'h0000_0700);
    wr(8'h68, 32'h0000_0000);
  endtask
  task automatic t_timing();
    logic [1:0] c;
    int lo_rcd, lo_ras, lo_rp;
    for (int k = 0; k < 6; k++) begin
      c = k % 3;
      wr(8'h60, {22'h0, k[2:0], c, 1'b0, c, c});
      step(1);
      chk(cas_half_clk_out, c == 0 ? 3'h5 : c == 1 ? 3'h4 : 3'h6);
      i_dtmc_seq_model.issue(1'b1, 2'h0);
      lo_rcd = 0;
      lo_ras = 0;
      repeat (12) begin
        lo_rcd += (rdwr_ok_out[0] !== 1'b1);
        lo_ras += (pre_ok_out[0] !== 1'b1);
        step(1);
      end
      chk(lo_rcd, 4 - c);
      chk(lo_ras, 10 - k);
      i_dtmc_seq_model.issue(1'b0, 2'h0);
      lo_rp = 0;
      repeat (6) begin
        lo_rp += (act_ok_out[0] !== 1'b1);
        step(1);
      end
      chk(lo_rp, 4 - c);
    end
  endtask
  task automatic t_due();
    wr(8'h60, 32'h0000_0400);
    i_dtmc_seq_model.issue(1'b1, 2'h3);
    chk(bank_open_out, 4'h8);
    step(134);
    chk(pre_due_out, 4'h0);
    step(1);
    chk(pre_due_out, 4'h8);
    i_dtmc_seq_model.issue(1'b0, 2'h3);
    chk({bank_open_out, pre_due_out}, 8'h00);
  endtask
  task automatic t_mode();
    logic [2:0] code [4] = '{3'h1, 3'h2, 3'h3, 3'h7};
    int per [4] = '{90, 70, 100, 64};
    int n;
    for (int i = 0; i < 4; i++) begin
      wr(8'h68, {2'b0, i[0], 9'h0, 1'b0, i[0], 7'h0, code[i], 8'h00});
      step(1);
      chk({init_done_out, ecc_enable_out}, {i[0], i[0]});
      wait_ref(n);
      chk(n + 1, per[i]);
      step(1);
      wait_ref(n);
      chk(n + 1, per[i]);
    end
    wr(8'h68, 32'h0000_0000);
  endtask
  task automatic t_strap();
    rst_in = 1'b1;
    dual_channel_in = 1'b1;
    step(2);
    rst_in = 1'b0;
    step(1);
    rd(8'h68, 32'h0020_0001);
    rd(8'h60, 32'h0000_0000);
  endtask
  initial begin
    step(5);
    rst_in = 1'b0;
    t_regs();
    t_timing();
    t_due();
    t_mode();
    t_strap();
    chk(i_dtmc_seq_model.n_stall, 32'h0000_0000);
    end_of_test();
  end
endmodule // tb_top
